// ==== shared/siob_pkg.sv ====
/*
  Shared constants and types for the serial client read and burst write block.
  Assumes the serial clock runs only while the client select is asserted.
*/
package siob_pkg;

  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_WRITE = 8'h02;

  // lanes per serial clock
  localparam logic [2:0] LANES_SINGLE = 3'h1;
  localparam logic [2:0] LANES_DUAL = 3'h2;
  localparam logic [2:0] LANES_QUAD = 3'h4;

  // burst sequencing code in address bits 15:14
  localparam int SEQ_MSB = 15;
  localparam int SEQ_LSB = 14;
  localparam logic [1:0] SEQ_CONST = 2'h0;
  localparam logic [1:0] SEQ_INC = 2'h1;
  localparam logic [1:0] SEQ_DEC = 2'h2;
  localparam logic [1:0] SEQ_RSVD = 2'h3;

  localparam int ADDR_W = 14;
  localparam int LEN_W = 14;
  localparam int LEN_EXT_BIT = 7;
  localparam logic [ADDR_W-1:0] WORD_STEP = 14'h0004;

  localparam logic [7:0] DUMMY_MIN_DUAL = 8'h02;
  localparam logic [7:0] DUMMY_MIN_QUAD = 8'h04;
  localparam logic [7:0] DUMMY_MAX = 8'hFF;
  localparam int SCK_MAX_MHZ = 80;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
  } siob_req_s;

  typedef struct packed {
    logic four_wire;
    logic [7:0] dummy_dual;
    logic [7:0] dummy_quad;
  } siob_cfg_s;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_LEN,
    ST_LEN2,
    ST_DUMMY,
    ST_DATA,
    ST_WDATA,
    ST_IGNORE
  } siob_state_e;

endpackage : siob_pkg

// ==== rtl/siob_sync2.sv ====
/*
  Two flip-flop level synchroniser, any width.
  Assumes multi-bit inputs are quasi-static or gray-like; no reset on purpose.
*/
`timescale 1ns/1ps
module siob_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end

endmodule : siob_sync2

// ==== rtl/siob_addr_seq.sv ====
/*
  Word address sequencer for multi-word writes on the serial clock.
  Assumes load and step never coincide; step marks one completed word.
*/
`timescale 1ns/1ps
module siob_addr_seq (
  input wire logic clk,
  input wire logic load,
  input wire logic [15:0] start_addr,
  input wire logic step,
  output logic [siob_pkg::ADDR_W-1:0] word_addr
);

  logic [1:0] mode;

  always_ff @(posedge clk) begin
    if (load) begin
      mode <= start_addr[siob_pkg::SEQ_MSB:siob_pkg::SEQ_LSB];
      word_addr <= {start_addr[siob_pkg::ADDR_W-1:2], 2'h0};
    end else if (step) begin
      case (mode)
        // [RULE18] next word up
        siob_pkg::SEQ_INC: word_addr <= word_addr + siob_pkg::WORD_STEP;
        // [RULE19] previous word
        siob_pkg::SEQ_DEC: word_addr <= word_addr - siob_pkg::WORD_STEP;
        // [RULE17] same word repeats
        default: word_addr <= word_addr;
      endcase
    end
  end

endmodule : siob_addr_seq

// ==== rtl/siob_serial_io.sv ====
/*
  Serial client port: dual and quad I/O reads and single-line burst writes.
  Link logic runs on sck and is framed by client_select_n; register accesses
  cross to clk by toggle handshake. Assumes the register side answers each
  reg_req with one reg_ack pulse, and config inputs are quasi-static.
*/
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] dual read BBh, then args two lanes
// [RULE2] host gives 2 to 255 dual dummies
// [RULE3] quad read EBh, then args four lanes
// [RULE4] host gives 4 to 255 quad dummies
// [RULE5] reads refused in four-wire protocol; 80 MHz
// [RULE6] length: 7-bit one byte, 14-bit two
// [RULE7] length counts data bytes only
// [RULE8] dual data starts after last dummy
// [RULE9] quad data starts after last dummy
// [RULE10] unaligned start sends uncounted padding bytes
// [RULE11] data bytes and words follow gaplessly
// [RULE12] select high releases data lines
// [RULE13] no dummies after last data byte
// [RULE14] host keeps clocking for multi-word writes
// [RULE15] address bits 15:14 choose word sequencing
// [RULE16] byte address increments inside each word
// [RULE17] constant mode rewrites same word
// [RULE18] increment mode adds four per word
// [RULE19] decrement mode subtracts four per word
// [RULE20] host never uses sequencing code 11
// [RULE21] select high abandons command decode
module siob_serial_io (
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic client_select_n,
  input wire logic [3:0] serial_data_lines_in,
  output logic [3:0] serial_data_lines_out,
  output logic [3:0] serial_data_lines_oe_n,
  input wire logic four_wire_command_protocol,
  input wire logic [7:0] init_dummy_dual,
  input wire logic [7:0] init_dummy_quad,
  output logic reg_req,
  output logic reg_wr,
  output logic [siob_pkg::ADDR_W-1:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata
);

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] d, input logic [2:0] w);
    case (w)
      siob_pkg::LANES_QUAD: shift_in = {sh[3:0], d};
      siob_pkg::LANES_DUAL: shift_in = {sh[5:0], d[1:0]};
      default: shift_in = {sh[6:0], d[0]};
    endcase
  endfunction : shift_in

  function automatic logic [2:0] last_slot(input logic [2:0] w);
    case (w)
      siob_pkg::LANES_QUAD: last_slot = 3'h1;
      siob_pkg::LANES_DUAL: last_slot = 3'h3;
      default: last_slot = 3'h7;
    endcase
  endfunction : last_slot

  // msb-first slice of a byte on the active lanes
  function automatic logic [3:0] out_lanes(input logic [7:0] b, input logic [2:0] slot, input logic quad);
    if (quad) begin
      out_lanes = slot[0] ? b[3:0] : b[7:4];
    end else begin
      case (slot[1:0])
        2'h0: out_lanes = {2'h0, b[7:6]};
        2'h1: out_lanes = {2'h0, b[5:4]};
        2'h2: out_lanes = {2'h0, b[3:2]};
        default: out_lanes = {2'h0, b[1:0]};
      endcase
    end
  endfunction : out_lanes

  // link domain
  siob_pkg::siob_state_e state;
  siob_pkg::siob_cfg_s cfg_link;
  siob_pkg::siob_req_s link_req;
  logic srst_link;
  logic [7:0] shreg;
  logic [2:0] slot;
  logic byte_cnt;
  logic [7:0] addr_hi;
  logic [15:0] start_addr;
  logic [siob_pkg::LEN_W-1:0] len_left;
  logic [7:0] dummy_left;
  logic is_quad;
  logic is_write;
  logic first_edge;
  logic drop_stale;
  logic fetch_en;
  logic [siob_pkg::ADDR_W-1:0] fetch_addr;
  logic [31:0] cur_word;
  logic [31:0] next_word;
  logic have_cur;
  logic have_next;
  logic first_word;
  logic [1:0] out_idx;
  logic [1:0] wr_lane;
  logic [31:0] wdata;
  logic req_tgl;
  logic ack_seen;
  logic ack_sync;
  // core domain
  logic req_sync;
  logic req_seen;
  logic core_busy;
  logic ack_tgl;
  logic [31:0] rsp_data;

  logic [2:0] lane_w;
  logic [7:0] nb;
  logic slot_end;
  logic busy;
  logic ack_evt;
  logic ack_use;
  logic fetch_go;
  logic post_go;
  logic seq_load;
  logic word_done;
  logic counted;
  logic [7:0] cur_byte;
  logic [7:0] dummy_cfg;
  logic [31:0] wmerge;
  logic [siob_pkg::ADDR_W-1:0] seq_word_addr;

  siob_sync2 #(.W(1)) u_srst_link (
    .clk(sck),
    .d(srst),
    .q(srst_link)
  );

  siob_sync2 #(.W(17)) u_cfg_link (
    .clk(sck),
    .d({four_wire_command_protocol, init_dummy_dual, init_dummy_quad}),
    .q(cfg_link)
  );

  siob_sync2 #(.W(1)) u_ack_link (
    .clk(sck),
    .d(ack_tgl),
    .q(ack_sync)
  );

  siob_sync2 #(.W(1)) u_req_core (
    .clk(clk),
    .d(req_tgl),
    .q(req_sync)
  );

  always_comb begin
    if (state == siob_pkg::ST_CMD || is_write) begin
      lane_w = siob_pkg::LANES_SINGLE;
    end else if (is_quad) begin
      lane_w = siob_pkg::LANES_QUAD;
    end else begin
      lane_w = siob_pkg::LANES_DUAL;
    end
  end

  assign nb = shift_in(shreg, serial_data_lines_in, lane_w);
  assign slot_end = (slot == last_slot(lane_w));
  assign busy = (req_tgl != ack_seen);
  assign ack_evt = (ack_sync != ack_seen);
  assign ack_use = ack_evt && !drop_stale;
  assign cur_byte = cur_word[{out_idx, 3'h0} +: 8];
  // [RULE10] bytes below the start offset are padding
  assign counted = !(first_word && (out_idx < start_addr[1:0]));
  assign word_done = (state == siob_pkg::ST_DATA) && slot_end && (out_idx == 2'h3);
  assign fetch_go = fetch_en && !busy && !have_next && !drop_stale && !first_edge;
  assign post_go = (state == siob_pkg::ST_WDATA) && slot_end && (wr_lane == 2'h3) && !busy;
  assign seq_load = (state == siob_pkg::ST_ADDR) && slot_end && byte_cnt && is_write;

  // [RULE2] [RULE4] dummy count never below the documented minimum
  always_comb begin
    dummy_cfg = is_quad ? cfg_link.dummy_quad : cfg_link.dummy_dual;
    if (is_quad && dummy_cfg < siob_pkg::DUMMY_MIN_QUAD) begin
      dummy_cfg = siob_pkg::DUMMY_MIN_QUAD;
    end else if (!is_quad && dummy_cfg < siob_pkg::DUMMY_MIN_DUAL) begin
      dummy_cfg = siob_pkg::DUMMY_MIN_DUAL;
    end
  end

  // [RULE16] byte lanes fill in rising order
  always_comb begin
    wmerge = wdata;
    wmerge[{wr_lane, 3'h0} +: 8] = nb;
  end

  siob_addr_seq u_addr_seq (
    .clk(sck),
    .load(seq_load),
    .start_addr({addr_hi, nb}),
    .step(post_go),
    .word_addr(seq_word_addr)
  );

  // frame state; select high clears all of it, issued requests still complete
  always_ff @(posedge sck or posedge client_select_n) begin
    if (client_select_n) begin
      // [RULE21] restart at instruction byte
      state <= siob_pkg::ST_CMD;
      shreg <= 8'h00;
      slot <= 3'h0;
      byte_cnt <= 1'b0;
      addr_hi <= 8'h00;
      start_addr <= 16'h0000;
      len_left <= 14'h0000;
      dummy_left <= 8'h00;
      is_quad <= 1'b0;
      is_write <= 1'b0;
      first_edge <= 1'b1;
      drop_stale <= 1'b0;
      fetch_en <= 1'b0;
      fetch_addr <= 14'h0000;
      cur_word <= 32'h0000_0000;
      next_word <= 32'h0000_0000;
      have_cur <= 1'b0;
      have_next <= 1'b0;
      first_word <= 1'b1;
      out_idx <= 2'h0;
      wr_lane <= 2'h0;
      wdata <= 32'h0000_0000;
    end else begin
      first_edge <= 1'b0;
      if (first_edge) begin
        drop_stale <= busy;
      end else if (ack_evt) begin
        drop_stale <= 1'b0;
      end
      shreg <= nb;
      slot <= slot_end ? 3'h0 : slot + 3'h1;
      if (fetch_go) begin
        fetch_addr <= fetch_addr + siob_pkg::WORD_STEP;
      end
      // prefetch buffer: current word and one ahead
      if (word_done) begin
        first_word <= 1'b0;
        if (ack_use) begin
          cur_word <= have_next ? next_word : rsp_data;
          next_word <= rsp_data;
          have_next <= have_next;
        end else begin
          cur_word <= next_word;
          have_next <= 1'b0;
        end
      end else if (ack_use) begin
        if (!have_cur) begin
          cur_word <= rsp_data;
          have_cur <= 1'b1;
        end else begin
          next_word <= rsp_data;
          have_next <= 1'b1;
        end
      end
      case (state)
        siob_pkg::ST_CMD: begin
          if (slot_end) begin
            // [RULE5] reads refused under four-wire protocol
            if (cfg_link.four_wire) begin
              state <= siob_pkg::ST_IGNORE;
            // [RULE1] dual read opcode
            end else if (nb == siob_pkg::OP_DUAL_IO_READ) begin
              is_quad <= 1'b0;
              state <= siob_pkg::ST_ADDR;
            // [RULE3] quad read opcode
            end else if (nb == siob_pkg::OP_QUAD_IO_READ) begin
              is_quad <= 1'b1;
              state <= siob_pkg::ST_ADDR;
            end else if (nb == siob_pkg::OP_WRITE) begin
              is_write <= 1'b1;
              state <= siob_pkg::ST_ADDR;
            end else begin
              state <= siob_pkg::ST_IGNORE;
            end
          end
        end
        siob_pkg::ST_ADDR: begin
          if (slot_end) begin
            byte_cnt <= ~byte_cnt;
            if (!byte_cnt) begin
              addr_hi <= nb;
            end else begin
              start_addr <= {addr_hi, nb};
              wr_lane <= nb[1:0];
              fetch_addr <= {addr_hi[5:0], nb[7:2], 2'h0};
              fetch_en <= !is_write;
              state <= is_write ? siob_pkg::ST_WDATA : siob_pkg::ST_LEN;
            end
          end
        end
        siob_pkg::ST_LEN: begin
          if (slot_end) begin
            dummy_left <= dummy_cfg;
            // [RULE6] extension bit selects 14-bit length
            if (nb[siob_pkg::LEN_EXT_BIT]) begin
              len_left <= {nb[6:0], 7'h00};
              state <= siob_pkg::ST_LEN2;
            end else begin
              len_left <= {7'h00, nb[6:0]};
              state <= (nb[6:0] == 7'h00) ? siob_pkg::ST_IGNORE : siob_pkg::ST_DUMMY;
            end
          end
        end
        siob_pkg::ST_LEN2: begin
          if (slot_end) begin
            len_left <= {len_left[13:7], nb[6:0]};
            state <= ({len_left[13:7], nb[6:0]} == 14'h0000) ? siob_pkg::ST_IGNORE : siob_pkg::ST_DUMMY;
          end
        end
        siob_pkg::ST_DUMMY: begin
          if (slot_end) begin
            dummy_left <= dummy_left - 8'h01;
            // [RULE8] [RULE9] data follows the last dummy
            if (dummy_left == 8'h01) begin
              state <= siob_pkg::ST_DATA;
            end
          end
        end
        siob_pkg::ST_DATA: begin
          if (slot_end) begin
            // [RULE11] next byte follows without gap
            out_idx <= out_idx + 2'h1;
            // [RULE7] only data bytes decrement length
            if (counted) begin
              len_left <= len_left - 14'h0001;
              // [RULE13] stop after last data byte
              if (len_left == 14'h0001) begin
                state <= siob_pkg::ST_IGNORE;
                fetch_en <= 1'b0;
              end
            end
          end
        end
        siob_pkg::ST_WDATA: begin
          if (slot_end) begin
            wdata <= wmerge;
            wr_lane <= wr_lane + 2'h1;
          end
        end
        default: begin
          state <= siob_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // request channel to the register side
  always_ff @(posedge sck) begin
    if (srst_link) begin
      req_tgl <= 1'b0;
      ack_seen <= 1'b0;
      link_req <= '0;
    end else begin
      if (ack_evt) begin
        ack_seen <= ack_sync;
      end
      if (fetch_go) begin
        req_tgl <= ~req_tgl;
        link_req <= '{wr: 1'b0, addr: fetch_addr, data: 32'h0000_0000};
      // [RULE15] word address from sequencer
      end else if (post_go) begin
        req_tgl <= ~req_tgl;
        link_req <= '{wr: 1'b1, addr: seq_word_addr, data: wmerge};
      end
    end
  end

  // drive on falling edge
  always_ff @(negedge sck or posedge client_select_n) begin
    if (client_select_n) begin
      // [RULE12] release lines at frame end
      serial_data_lines_out <= 4'h0;
      serial_data_lines_oe_n <= 4'hF;
    end else if (state == siob_pkg::ST_DATA) begin
      // [RULE8] [RULE9] msb slice of low byte first
      serial_data_lines_out <= out_lanes(cur_byte, slot, is_quad);
      serial_data_lines_oe_n <= is_quad ? 4'h0 : 4'hC;
    end else begin
      serial_data_lines_out <= 4'h0;
      serial_data_lines_oe_n <= 4'hF;
    end
  end

  // register side handshake
  always_ff @(posedge clk) begin
    if (srst) begin
      req_seen <= 1'b0;
      core_busy <= 1'b0;
      ack_tgl <= 1'b0;
      rsp_data <= 32'h0000_0000;
      reg_req <= 1'b0;
      reg_wr <= 1'b0;
      reg_addr <= 14'h0000;
      reg_wdata <= 32'h0000_0000;
    end else begin
      reg_req <= 1'b0;
      if (!core_busy && (req_sync != req_seen)) begin
        req_seen <= req_sync;
        core_busy <= 1'b1;
        reg_req <= 1'b1;
        reg_wr <= link_req.wr;
        reg_addr <= link_req.addr;
        reg_wdata <= link_req.data;
      end else if (core_busy && reg_ack) begin
        core_busy <= 1'b0;
        rsp_data <= reg_rdata;
        ack_tgl <= ~ack_tgl;
      end
    end
  end

endmodule : siob_serial_io

// ==== test/siob_serial_io_asserts.sv ====
/* Port checker for siob_serial_io.
   Bound to every instance; sees top ports only. */
`timescale 1ns/1ps
module siob_serial_io_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic client_select_n,
  input wire logic [3:0] serial_data_lines_out,
  input wire logic [3:0] serial_data_lines_oe_n,
  input wire logic four_wire_command_protocol,
  input wire logic reg_req,
  input wire logic [siob_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_ack
);
  logic [5:0] rises;
  logic pending;
  // sck rises since select fell
  always_ff @(posedge sck or posedge client_select_n) begin
    if (client_select_n) begin
      rises <= 6'h00;
    end else if (rises != 6'h3F) begin
      rises <= rises + 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      pending <= 1'b0;
    end else if (reg_req) begin
      pending <= 1'b1;
    end else if (reg_ack) begin
      pending <= 1'b0;
    end
  end
  // shortest command phase is a quad read with four dummies
  sequence s_cmd_phase;
    !client_select_n && rises < 6'h16;
  endsequence
  a_sel_release: assert property (@(posedge clk) disable iff (srst)
    client_select_n |-> serial_data_lines_oe_n == 4'hF) else $error("lanes driven while deselected");
  a_drive_legal: assert property (@(posedge clk) disable iff (srst)
    serial_data_lines_oe_n inside {4'hF, 4'hC, 4'h0}) else $error("illegal lane enable");
  a_idle_out_zero: assert property (@(posedge clk) disable iff (srst)
    serial_data_lines_oe_n == 4'hF |-> serial_data_lines_out == 4'h0) else $error("idle lanes not zero");
  a_req_pulse: assert property (@(posedge clk) disable iff (srst)
    reg_req |=> !reg_req) else $error("request longer than one cycle");
  a_one_outstanding: assert property (@(posedge clk) disable iff (srst)
    reg_req |-> !pending) else $error("request before answer");
  a_req_aligned: assert property (@(posedge clk) disable iff (srst)
    reg_req |-> reg_addr[1:0] == 2'h0) else $error("unaligned word request");
  a_fourwire_quiet: assert property (@(posedge clk) disable iff (srst)
    four_wire_command_protocol && $past(four_wire_command_protocol, 8) |-> serial_data_lines_oe_n == 4'hF)
    else $error("drive in four-wire protocol");
  a_cmd_phase_quiet: assert property (@(posedge sck) disable iff (client_select_n)
    s_cmd_phase |-> serial_data_lines_oe_n == 4'hF) else $error("drive during command phase");
endmodule : siob_serial_io_asserts

bind siob_serial_io siob_serial_io_asserts u_chk (.clk, .srst, .sck, .client_select_n, .serial_data_lines_out,
  .serial_data_lines_oe_n, .four_wire_command_protocol, .reg_req, .reg_addr, .reg_ack);

// ==== test/siob_host.sv ====
/* Serial host model: makes sck, frames the select, resolves lanes.
   Assumes sck idles low and only runs inside frames. */
`timescale 1ns/1ps
module siob_host (
  output logic sck,
  output logic client_select_n,
  output logic [3:0] serial_data_lines_in,
  input wire logic [3:0] serial_data_lines_out,
  input wire logic [3:0] serial_data_lines_oe_n
);
  logic [3:0] drv = 4'h0;
  logic en = 1'b0;
  logic [3:0] last = 4'h0;
  // clean rising select at start clears the frame logic
  initial begin
    sck = 1'b0;
    client_select_n = 1'b0;
    #1 client_select_n = 1'b1;
  end
  // released lanes show the inverse of the last level, no pull
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      serial_data_lines_in[i] = !serial_data_lines_oe_n[i] ? serial_data_lines_out[i] : en ? drv[i] : !last[i];
    end
  end
  always @(posedge sck) last <= serial_data_lines_in;
  task automatic tick();
    #62.5 sck = 1'b1;
    #62.5 sck = 1'b0;
  endtask : tick
  task automatic put(input logic [7:0] b, input int w);
    for (int s = 8 - w; s >= 0; s -= w) begin
      en = 1'b1;
      drv = 4'(b >> s) & 4'((1 << w) - 1);
      tick();
    end
  endtask : put
  task automatic get(output logic [7:0] b, input int w);
    b = 8'h00;
    en = 1'b0;
    for (int s = 0; s < 8; s += w) begin
      #62.5 sck = 1'b1;
      b = (b << w) | 8'(serial_data_lines_in & 4'((1 << w) - 1));
      #62.5 sck = 1'b0;
    end
  endtask : get
  task automatic sel(input logic on);
    en = 1'b0;
    #40 client_select_n = !on;
    #40;
  endtask : sel
endmodule : siob_host

// ==== test/test_siob_serial_io.sv ====
/* Self-checking bench for siob_serial_io with host model and register responder.
   Assumes the shared package is compiled first. */
`timescale 1ns/1ps
module test_siob_serial_io;
  logic clk;
  logic srst;
  logic sck, client_select_n;
  logic [3:0] serial_data_lines_in, serial_data_lines_out, serial_data_lines_oe_n;
  logic four_wire_command_protocol;
  logic [7:0] init_dummy_dual;
  logic [7:0] init_dummy_quad;
  logic reg_req, reg_wr, reg_ack;
  logic [siob_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [13:0] wa[$];
  logic [31:0] wd[$];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  siob_serial_io dut (.clk, .srst, .sck, .client_select_n, .serial_data_lines_in, .serial_data_lines_out,
    .serial_data_lines_oe_n, .four_wire_command_protocol, .init_dummy_dual, .init_dummy_quad, .reg_req,
    .reg_wr, .reg_addr, .reg_wdata, .reg_ack, .reg_rdata);
  siob_host h (.sck, .client_select_n, .serial_data_lines_in, .serial_data_lines_out, .serial_data_lines_oe_n);
  function automatic logic [31:0] word_of(input logic [13:0] a);
    return {a[7:0] ^ 8'h5A, 2'h0, a[13:8], ~a[7:0], a[7:0]};
  endfunction : word_of
  function automatic logic [7:0] byte_at(input logic [13:0] p);
    return 8'(word_of({p[13:2], 2'h0}) >> {p[1:0], 3'h0});
  endfunction : byte_at
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // register side: one answer per request, random latency
  initial begin
    logic [13:0] a;
    reg_ack = 1'b0;
    reg_rdata = 32'h0000_0000;
    forever begin
      if (reg_req === 1'b1) begin
        a = reg_addr;
        if (reg_wr) begin
          wa.push_back(reg_addr);
          wd.push_back(reg_wdata);
        end
        repeat ($urandom_range(0, 3)) @(posedge clk);
        @(posedge clk);
        #1 reg_ack = 1'b1;
        reg_rdata = word_of(a);
        @(posedge clk);
        #1 reg_ack = 1'b0;
        reg_rdata = ~reg_rdata;
      end else begin
        @(posedge clk);
        #1;
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      summarize();
    end
  end
  task automatic do_read(input logic q, input logic [13:0] a, input int len, input logic [7:0] dc, input int stop);
    int w, nd;
    logic [7:0] b;
    w = q ? 4 : 2;
    nd = (dc < w) ? w : dc;
    if (stop < 0) stop = len + a[1:0];
    @(posedge clk);
    #1;
    init_dummy_dual = dc;
    init_dummy_quad = dc;
    h.sel(1'b1);
    h.put(q ? siob_pkg::OP_QUAD_IO_READ : siob_pkg::OP_DUAL_IO_READ, 1);
    h.put({2'h0, a[13:8]}, w);
    h.put(a[7:0], w);
    if (len > 127) h.put({1'b1, 7'(len >> 7)}, w);
    h.put({1'b0, 7'(len)}, w);
    repeat (nd) h.put(8'($urandom), w);
    for (int n = 0; n < stop; n++) begin
      h.get(b, w);
      if (four_wire_command_protocol) begin
        check(32'(serial_data_lines_oe_n), 32'h0000_000F);
      end else begin
        check(32'(b), 32'(byte_at(a - 14'(a[1:0]) + 14'(n))));
      end
    end
    #1;
    if (stop == len + a[1:0]) check(32'(serial_data_lines_oe_n), 32'h0000_000F);
    h.sel(1'b0);
    check(32'(serial_data_lines_oe_n), 32'h0000_000F);
  endtask : do_read
  task automatic do_write(input logic [1:0] m, input int nw);
    logic [13:0] base, ea;
    logic [31:0] ed[$];
    logic [31:0] d;
    base = 14'($urandom_range(64, 3000) * 4);
    wa.delete();
    wd.delete();
    h.sel(1'b1);
    h.put(siob_pkg::OP_WRITE, 1);
    h.put({m, base[13:8]}, 1);
    h.put(base[7:0], 1);
    repeat (nw) begin
      d = $urandom;
      ed.push_back(d);
      for (int k = 0; k < 4; k++) h.put(d[8*k +: 8], 1);
    end
    h.put(8'h3C, 1);
    h.sel(1'b0);
    repeat (20) @(posedge clk);
    check(32'(wa.size()), 32'(nw));
    for (int k = 0; k < nw; k++) begin
      ea = (m == siob_pkg::SEQ_INC) ? base + 14'(4 * k) : base;
      ea = (m == siob_pkg::SEQ_DEC) ? base - 14'(4 * k) : ea;
      check(wd[k], ed[k]);
      check(32'(wa[k]), 32'(ea));
    end
  endtask : do_write
  initial begin
    srst = 1'b1;
    four_wire_command_protocol = 1'b0;
    init_dummy_dual = 8'h00;
    init_dummy_quad = 8'h00;
    void'($urandom(99350));
    h.sel(1'b1);
    repeat (4) h.tick();
    h.sel(1'b0);
    @(posedge clk);
    #1 srst = 1'b0;
    repeat (10) @(posedge clk);
    do_read(1'b0, 14'h0010, 4, 8'h00, -1);
    do_read(1'b1, 14'h0023, 5, 8'h01, -1);
    do_read(1'b0, 14'h0101, 130, 8'h03, -1);
    do_read(1'b1, 14'h0042, 6, 8'h05, 3);
    h.sel(1'b1);
    h.put(siob_pkg::OP_DUAL_IO_READ, 1);
    h.put(8'h00, 2);
    h.sel(1'b0);
    check(32'(serial_data_lines_oe_n), 32'h0000_000F);
    for (int i = 0; i < 6; i++) begin
      do_read(1'($urandom), 14'($urandom_range(0, 16'h3F00)), $urandom_range(1, 12), 8'($urandom_range(0, 6)), -1);
    end
    four_wire_command_protocol = 1'b1;
    do_read(1'b0, 14'h0004, 4, 8'h02, 4);
    four_wire_command_protocol = 1'b0;
    repeat (10) @(posedge clk);
    // host keeps to codes 00, 01 and 10
    for (int m = 0; m < 3; m++) do_write(2'(m), 3);
    summarize();
  end
endmodule : test_siob_serial_io
